// [sfw_map.svh]
`ifndef SFW_MAP_SVH
`define SFW_MAP_SVH

// array opcodes: bit 3 carries the ninth address bit
`define SFW_OP_WRITE_LO 8'h02
`define SFW_OP_WRITE_HI 8'h0a
`define SFW_OP_READ_LO 8'h03
`define SFW_OP_READ_HI 8'h0b
`define SFW_OP_ARRAY_MASK 8'hf7
`define SFW_ADDR_MSB_BIT 3

// non-array command opcodes
`define SFW_OP_SET_LATCH 8'h06
`define SFW_OP_CLEAR_LATCH 8'h04
`define SFW_OP_STATUS_RD 8'h05
`define SFW_OP_STATUS_WR 8'h01

// device_status layout
`define SFW_ST_LATCH_BIT 1
`define SFW_ST_PROT_LO_BIT 2
`define SFW_ST_PROT_HI_BIT 3
`define SFW_ST_RESET 8'h00

// array geometry, protected region bases and receive fifo depth
`define SFW_ADDR_W 9
`define SFW_DEPTH 512
`define SFW_QUARTER_BASE 9'h180
`define SFW_HALF_BASE 9'h100
`define SFW_FIFO_DEPTH 16

`endif

// [sfw_pkg.sv]
package sfw_pkg;

  typedef enum logic [2:0] {
    SFW_IDLE,
    SFW_ADDR,
    SFW_WDATA,
    SFW_RDATA,
    SFW_SRWR,
    SFW_SRRD,
    SFW_SKIP
  } sfw_state_t;

  typedef struct packed {
    sfw_state_t state;
    logic latch;
    logic [1:0] prot;
    logic [8:0] addr;
    logic is_read;
    logic hi_write;
    logic wrote;
    logic rd_pend;
    logic [7:0] tx_byte;
    logic [2:0] tog_sync;
    logic [1:0] cs_sync;
    logic in_frame;
    logic overrun;
  } sfw_core_t;

  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] cnt;
  } sfw_rx_t;

  typedef struct packed {
    logic [7:0] hold;
    logic tog;
  } sfw_rxo_t;

  typedef struct packed {
    logic [6:0] shift;
    logic miso;
    logic oe_n;
  } sfw_tx_t;

endpackage

// [sfw_byte_if.sv]
`timescale 1ns/100ps
interface sfw_byte_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// [sfw_fifo.sv]
`timescale 1ns/100ps
module sfw_fifo
  import sfw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  sfw_byte_if.snk push,
  sfw_byte_if.src pop
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0] wptr;
    logic [PW:0] rptr;
  } sfw_fifo_state_t;

  sfw_fifo_state_t st;
  sfw_fifo_state_t next_st;
  logic full;
  logic empty;

  assign empty = (st.wptr == st.rptr);
  assign full = (st.wptr[PW] != st.rptr[PW]) && (st.wptr[PW-1:0] == st.rptr[PW-1:0]);
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = st.mem[st.rptr[PW-1:0]];

  always_comb begin
    next_st = st;
    if (push.valid && !full) begin
      next_st.mem[st.wptr[PW-1:0]] = push.data;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (!empty && pop.ready) begin
      next_st.rptr = st.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// [sfw_mem.sv]
`timescale 1ns/100ps
`include "sfw_map.svh"
module sfw_mem
  import sfw_pkg::*;
(
  input wire logic clk_in,
  input wire logic [8:0] addr_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  // nonvolatile cells: no reset, contents survive the block reset
  logic [7:0] cells [0:`SFW_DEPTH-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      cells[addr_in] <= wdata_in;
    end
    rdata_out <= cells[addr_in];
  end
endmodule

// [sfw_spi_fram.sv]
`timescale 1ns/100ps
`include "sfw_map.svh"
module sfw_spi_fram
  import sfw_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_n_out,
  output logic write_latch_flag_out,
  output logic overrun_out
);
  localparam sfw_tx_t TX_RESET = '{shift: 7'h00, miso: 1'b0, oe_n: 1'b1};
  // select idles high, so its synchroniser resets high: no false frame
  // start when reset lifts while the host is deselected
  localparam sfw_core_t CORE_RESET = '{state: SFW_IDLE, cs_sync: 2'h3, default: '0};

  sfw_rx_t rx;
  sfw_rx_t next_rx;
  sfw_rxo_t rxo;
  sfw_rxo_t next_rxo;
  sfw_tx_t tx;
  sfw_tx_t next_tx;
  sfw_core_t c;
  sfw_core_t next_c;

  logic link_rst;
  logic byte_evt;
  logic take;
  logic frame_end;
  logic [7:0] b;
  logic [7:0] status;
  logic [8:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_rdata;

  sfw_byte_if #(.W(8)) rx_if();
  sfw_byte_if #(.W(8)) pop_if();

  // link side: deselect also clears the bit counter, so every frame
  // starts on a byte boundary even after a truncated byte
  assign link_rst = reset_in | spi_cs_n_in;

  always_comb begin
    next_rx = rx;
    next_rx.shift = {rx.shift[5:0], spi_mosi_in};
    next_rx.cnt = rx.cnt + 3'h1;
  end

  always_ff @(posedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // completed byte is parked in hold and announced by a toggle; hold stays
  // stable for a full byte time, far longer than the core needs to sample
  always_comb begin
    next_rxo = rxo;
    if (rx.cnt == 3'h7) begin
      next_rxo.hold = {rx.shift, spi_mosi_in};
      next_rxo.tog = ~rxo.tog;
    end
  end

  always_ff @(posedge spi_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rxo <= '0;
    end else begin
      rxo <= next_rxo;
    end
  end

  // answer bits leave on the falling edge; tx_byte is quasi-static here
  // because the host stretches the clock high after each byte
  always_comb begin
    next_tx = tx;
    next_tx.oe_n = 1'b0;
    if (rx.cnt == 3'h0) begin
      next_tx.miso = c.tx_byte[7];
      next_tx.shift = c.tx_byte[6:0];
    end else begin
      next_tx.miso = tx.shift[6];
      next_tx.shift = {tx.shift[5:0], 1'b0};
    end
  end

  always_ff @(negedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      tx <= TX_RESET;
    end else begin
      tx <= next_tx;
    end
  end

  assign spi_miso_out = tx.miso;
  assign spi_miso_oe_n_out = tx.oe_n;

  // core side
  assign byte_evt = c.tog_sync[2] ^ c.tog_sync[1];
  assign rx_if.valid = byte_evt;
  assign rx_if.data = rxo.hold;
  // a pending array read stalls the drain, which backs up the fifo
  assign pop_if.ready = !c.rd_pend;
  assign take = pop_if.valid && pop_if.ready;
  assign b = pop_if.data;
  // frame is closed only once every byte of it has been decoded
  assign frame_end = c.in_frame && c.cs_sync[1] && !pop_if.valid && !c.rd_pend;

  always_comb begin
    status = `SFW_ST_RESET;
    status[`SFW_ST_LATCH_BIT] = c.latch;
    status[`SFW_ST_PROT_LO_BIT] = c.prot[0];
    status[`SFW_ST_PROT_HI_BIT] = c.prot[1];
  end

  function automatic logic is_protected(input logic [8:0] a, input logic [1:0] p);
    logic r;
    r = 1'b0;
    case (p)
      2'h1: r = (a >= `SFW_QUARTER_BASE);
      2'h2: r = (a >= `SFW_HALF_BASE);
      2'h3: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    next_c = c;
    mem_we = 1'b0;
    mem_addr = c.addr;
    next_c.cs_sync = {c.cs_sync[0], spi_cs_n_in};
    next_c.tog_sync = {c.tog_sync[1:0], rxo.tog};
    if (byte_evt && !rx_if.ready) begin
      next_c.overrun = 1'b1;
    end
    if (!c.cs_sync[1]) begin
      next_c.in_frame = 1'b1;
    end
    if (c.rd_pend) begin
      next_c.tx_byte = mem_rdata;
      next_c.rd_pend = 1'b0;
    end
    if (take) begin
      case (c.state)
        SFW_IDLE: begin
          next_c.state = SFW_SKIP;
          if (b == `SFW_OP_SET_LATCH) begin
            next_c.latch = 1'b1;
          end else if (b == `SFW_OP_CLEAR_LATCH) begin
            next_c.latch = 1'b0;
          end else if (b == `SFW_OP_STATUS_RD) begin
            next_c.tx_byte = status;
            next_c.state = SFW_SRRD;
          end else if (b == `SFW_OP_STATUS_WR) begin
            if (c.latch) begin
              next_c.state = SFW_SRWR;
            end
          end else if ((b & `SFW_OP_ARRAY_MASK) == `SFW_OP_READ_LO) begin
            next_c.addr[8] = b[`SFW_ADDR_MSB_BIT];
            next_c.is_read = 1'b1;
            next_c.state = SFW_ADDR;
          end else if ((b & `SFW_OP_ARRAY_MASK) == `SFW_OP_WRITE_LO) begin
            if (c.latch) begin
              next_c.addr[8] = b[`SFW_ADDR_MSB_BIT];
              next_c.is_read = 1'b0;
              next_c.hi_write = (b == `SFW_OP_WRITE_HI);
              next_c.state = SFW_ADDR;
            end
          end
        end
        SFW_ADDR: begin
          next_c.addr[7:0] = b;
          if (c.is_read) begin
            mem_addr = {c.addr[8], b};
            next_c.addr = mem_addr + 9'h001;
            next_c.rd_pend = 1'b1;
            next_c.state = SFW_RDATA;
          end else begin
            next_c.state = SFW_WDATA;
          end
        end
        SFW_WDATA: begin
          mem_we = !is_protected(c.addr, c.prot);
          next_c.addr = c.addr + 9'h001;
          next_c.wrote = 1'b1;
        end
        SFW_RDATA: begin
          next_c.addr = c.addr + 9'h001;
          next_c.rd_pend = 1'b1;
        end
        SFW_SRWR: begin
          next_c.prot = {b[`SFW_ST_PROT_HI_BIT], b[`SFW_ST_PROT_LO_BIT]};
          next_c.wrote = 1'b1;
          next_c.state = SFW_SKIP;
        end
        SFW_SRRD: begin
          next_c.tx_byte = status;
        end
        SFW_SKIP: begin
          next_c.state = SFW_SKIP;
        end
        default: begin
          next_c.state = SFW_SKIP;
        end
      endcase
    end
    if (frame_end) begin
      // the upper-half write opcode never reaches the auto-clear
      if (c.wrote && !c.hi_write) begin
        next_c.latch = 1'b0;
      end
      next_c.wrote = 1'b0;
      next_c.hi_write = 1'b0;
      next_c.in_frame = 1'b0;
      next_c.state = SFW_IDLE;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      c <= CORE_RESET;
    end else begin
      c <= next_c;
    end
  end

  assign write_latch_flag_out = c.latch;
  assign overrun_out = c.overrun;

  sfw_fifo #(
    .WIDTH(8),
    .DEPTH(`SFW_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .push(rx_if.snk),
    .pop(pop_if.src)
  );

  sfw_mem u_mem (
    .clk_in(clk_in),
    .addr_in(mem_addr),
    .we_in(mem_we),
    .wdata_in(b),
    .rdata_out(mem_rdata)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // checks sample settled core state only; link timing rides on the
  // asynchronous host clock and is left to the bench
  chk_set_latch: assert property (
    take && c.state == SFW_IDLE && b == `SFW_OP_SET_LATCH |=> c.latch)
    else $error("set command did not set latch");
  chk_write_gate: assert property (
    mem_we |-> c.latch)
    else $error("array written with latch clear");
  chk_write_refused: assert property (
    take && c.state == SFW_IDLE && !c.latch
    && ((b & `SFW_OP_ARRAY_MASK) == `SFW_OP_WRITE_LO || b == `SFW_OP_STATUS_WR)
    |=> c.state == SFW_SKIP)
    else $error("write accepted with latch clear");
  chk_sr_latch: assert property (
    take && c.state == SFW_SRWR |=> c.latch == $past(c.latch))
    else $error("status write changed latch");
  chk_auto_clear: assert property (
    frame_end && c.wrote && !c.hi_write |=> !c.latch && c.state == SFW_IDLE)
    else $error("latch not cleared after write");
  chk_latch_steady: assert property (
    !take && !frame_end |=> c.latch == $past(c.latch))
    else $error("latch moved without a command or frame end");
  chk_frame_close: assert property (
    frame_end |=> c.state == SFW_IDLE && !c.wrote && !c.hi_write)
    else $error("frame end left write state behind");
  chk_upper_keep: assert property (
    frame_end && c.hi_write && c.latch |=> c.latch)
    else $error("upper-half write cleared latch");
  chk_hi_mark: assert property (
    take && c.state == SFW_IDLE && c.latch && (b & `SFW_OP_ARRAY_MASK) == `SFW_OP_WRITE_LO
    |=> c.hi_write == $past(b[3]))
    else $error("upper-half write not marked");
  chk_reset_latch: assert property (@(posedge clk_in) disable iff (1'b0)
    reset_in |=> !c.latch)
    else $error("latch set after reset");
  chk_status_zero: assert property (
    c.state == SFW_SRRD |-> c.tx_byte[0] == 1'b0 && c.tx_byte[7:4] == 4'h0)
    else $error("status spare bits set");
  chk_status_snap: assert property (
    take && c.state == SFW_IDLE && b == `SFW_OP_STATUS_RD
    |=> c.tx_byte == {4'h0, $past(c.prot), $past(c.latch), 1'b0})
    else $error("status answer wrong");
  chk_prot_load: assert property (
    take && c.state == SFW_SRWR |=> c.prot == $past(b[3:2]))
    else $error("protect selects not loaded");
  chk_prot_all: assert property (
    c.prot == 2'h3 |-> !mem_we)
    else $error("array written while fully protected");
  chk_array_write: assert property (
    take && c.state == SFW_WDATA && c.prot == 2'h0 |-> mem_we)
    else $error("unprotected data byte not written");
  chk_addr_msb: assert property (
    take && c.state == SFW_IDLE && c.latch && (b & `SFW_OP_ARRAY_MASK) == `SFW_OP_WRITE_LO
    |=> c.state == SFW_ADDR && c.addr[8] == $past(b[3]))
    else $error("address msb not taken from opcode");
  chk_read_msb: assert property (
    take && c.state == SFW_IDLE && (b & `SFW_OP_ARRAY_MASK) == `SFW_OP_READ_LO
    |=> c.state == SFW_ADDR && c.is_read && c.addr[8] == $past(b[3]))
    else $error("read opcode not decoded");
  chk_read_fill: assert property (
    take && c.state == SFW_ADDR && c.is_read
    |=> c.rd_pend ##1 (c.tx_byte == $past(mem_rdata) && !c.rd_pend))
    else $error("read data not loaded");
  chk_clear_cmd: assert property (
    take && c.state == SFW_IDLE && b == `SFW_OP_CLEAR_LATCH |=> !c.latch)
    else $error("clear command did not clear latch");
  chk_addr_byte: assert property (
    take && c.state == SFW_ADDR && !c.is_read
    |=> c.addr[7:0] == $past(b) && c.state == SFW_WDATA)
    else $error("address byte not captured");
  chk_addr_step: assert property (
    take && c.state == SFW_WDATA |=> c.addr == $past(c.addr) + 9'h001)
    else $error("write address did not advance");

  cov_upper_write: cover property (take && c.state == SFW_WDATA && c.hi_write);
  cov_status_read: cover property (take && c.state == SFW_SRRD);
  cov_array_read: cover property (c.rd_pend && c.state == SFW_RDATA);
  cov_auto_clear: cover property (frame_end && c.wrote && !c.hi_write && c.latch);
  cov_write_refused: cover property (take && c.state == SFW_IDLE && !c.latch
    && (b & `SFW_OP_ARRAY_MASK) == `SFW_OP_WRITE_LO);
endmodule

// [sfw_host.sv]
`timescale 1ns/100ps
module sfw_host (
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in,
  input wire logic spi_miso_oe_n_in
);
  localparam realtime HALF = 16.0;
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end
  // clock runs only inside frames; the odd start offset keeps it off the core clock's phase
  task automatic frame(input logic [7:0] tx [8], input int n, output logic [7:0] rx [8]);
    logic [7:0] b;
    b = 8'h00;
    spi_cs_n_out = 1'b0;
    #23.3;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        spi_mosi_out = tx[k][i];
        #(HALF);
        spi_clk_out = 1'b1;
        // a released line floats; seeing the inverse catches a missing enable
        b[i] = spi_miso_oe_n_in ? ~spi_miso_in : spi_miso_in;
        // long high stretch after the last bit lets the core prepare its answer
        #((i == 0) ? 240.0 : HALF);
        spi_clk_out = 1'b0;
      end
      rx[k] = b;
    end
    #(HALF);
    spi_mosi_out = ~spi_mosi_out;
    spi_cs_n_out = 1'b1;
    #130;
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
`include "sfw_map.svh"
module tb_top;
  import sfw_pkg::*;
  logic clk_in, reset_in, spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_oe_n;
  logic latch_flag, overrun;
  logic [7:0] seen_flag, d1, d2;
  logic [7:0] tx [8];
  logic [7:0] rx [8];
  logic [7:0] m_mem [512];
  logic m_latch;
  logic [1:0] m_prot;
  int bad_count, check_count;
  assign seen_flag = {7'h00, latch_flag};
  sfw_spi_fram sfw_spi_fram_i (.clk_in(clk_in), .reset_in(reset_in), .spi_clk_in(spi_clk),
    .spi_cs_n_in(spi_cs_n), .spi_mosi_in(spi_mosi), .spi_miso_out(spi_miso),
    .spi_miso_oe_n_out(spi_oe_n), .write_latch_flag_out(latch_flag), .overrun_out(overrun));
  sfw_host sfw_host_i (.spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n),
    .spi_mosi_out(spi_mosi), .spi_miso_in(spi_miso), .spi_miso_oe_n_in(spi_oe_n));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic is_prot(input logic [8:0] a);
    case (m_prot)
      2'b00: return 1'b0;
      2'b01: return a >= `SFW_QUARTER_BASE;
      2'b10: return a >= `SFW_HALF_BASE;
      default: return 1'b1;
    endcase
  endfunction
  task automatic run(input int n);
    sfw_host_i.frame(tx, n, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    tx[0] = op;
    run(1);
    if (op == `SFW_OP_SET_LATCH) m_latch = 1'b1;
    if (op == `SFW_OP_CLEAR_LATCH) m_latch = 1'b0;
  endtask
  task automatic mem_write(input logic hi, input logic [7:0] a, input logic [7:0] d);
    tx[0] = hi ? `SFW_OP_WRITE_HI : `SFW_OP_WRITE_LO;
    tx[1] = a;
    tx[2] = d;
    run(3);
    if (m_latch && !is_prot({hi, a})) m_mem[{hi, a}] = d;
    // only the lower-half opcode ends the enable
    if (!hi) m_latch = 1'b0;
  endtask
  task automatic mem_read(input logic hi, input logic [7:0] a);
    tx[0] = hi ? `SFW_OP_READ_HI : `SFW_OP_READ_LO;
    tx[1] = a;
    tx[2] = 8'($urandom);
    run(3);
    check(rx[2], m_mem[{hi, a}]);
  endtask
  task automatic status_rd();
    tx[0] = `SFW_OP_STATUS_RD;
    tx[1] = 8'h00;
    run(2);
    check(rx[1], {4'h0, m_prot, m_latch, 1'b0});
    check({7'h00, spi_oe_n}, 8'h01);
  endtask
  task automatic status_wr(input logic [7:0] v);
    tx[0] = `SFW_OP_STATUS_WR;
    tx[1] = v;
    run(2);
    if (m_latch) m_prot = v[3:2];
    m_latch = 1'b0;
  endtask
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  initial begin
    reset_in = 1'b1;
    m_latch = 1'b0;
    m_prot = 2'b00;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
    void'($urandom(32'h8fcea135));
    d1 = 8'($urandom);
    d2 = ~d1;
    check(seen_flag, 8'h00);
    status_rd();
    cmd(`SFW_OP_SET_LATCH);
    check(seen_flag, {7'h00, m_latch});
    status_rd();
    mem_write(1'b0, 8'h5a, d1);
    check(seen_flag, {7'h00, m_latch});
    mem_read(1'b0, 8'h5a);
    cmd(`SFW_OP_SET_LATCH);
    mem_write(1'b1, 8'h5a, d2);
    check(seen_flag, {7'h00, m_latch});
    mem_write(1'b1, 8'h90, d1);
    mem_read(1'b1, 8'h5a);
    mem_read(1'b0, 8'h5a);
    mem_write(1'b0, 8'h5a, d2);
    check(seen_flag, {7'h00, m_latch});
    mem_write(1'b1, 8'h5a, d1);
    mem_read(1'b1, 8'h5a);
    cmd(`SFW_OP_SET_LATCH);
    cmd(`SFW_OP_CLEAR_LATCH);
    check(seen_flag, {7'h00, m_latch});
    mem_write(1'b0, 8'h5a, d1);
    mem_read(1'b0, 8'h5a);
    cmd(`SFW_OP_SET_LATCH);
    status_wr(8'hf6);
    check(seen_flag, {7'h00, m_latch});
    status_rd();
    status_wr(8'h08);
    status_rd();
    cmd(`SFW_OP_SET_LATCH);
    mem_write(1'b1, 8'h5a, d1);
    mem_write(1'b1, 8'h90, d2);
    mem_read(1'b1, 8'h5a);
    mem_read(1'b1, 8'h90);
    status_wr(8'h00);
    status_rd();
    for (int k = 0; k < 12; k++) begin
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      cmd(`SFW_OP_SET_LATCH);
      mem_write(d2[0], d1, d2);
      check(seen_flag, {7'h00, m_latch});
      mem_read(d2[0], d1);
      cmd(`SFW_OP_CLEAR_LATCH);
      check(seen_flag, 8'h00);
    end
    cmd(`SFW_OP_SET_LATCH);
    status_wr(8'h0c);
    cmd(`SFW_OP_SET_LATCH);
    mem_write(d2[0], d1, ~d2);
    mem_read(d2[0], d1);
    cmd(`SFW_OP_SET_LATCH);
    // mid-run reset: latch and protect selects drop, array contents stay
    @(negedge clk_in);
    reset_in = 1'b1;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    m_latch = 1'b0;
    m_prot = 2'b00;
    repeat (2) @(negedge clk_in);
    check(seen_flag, 8'h00);
    status_rd();
    mem_read(d2[0], d1);
    check({7'h00, overrun}, 8'h00);
    stop_test();
  end
endmodule
